// *** pkg/aig_pkg.sv ***
// Purpose: Shared constants and types for the adaptive illumination gain
// Assumes: 8-bit colour channels, gains in 4.8 fixed point
// Notes:   Every width, count and limit used by more than one file lives here, except the 16-bit sink word count
package aig_pkg;
	localparam int NCH     = 3;   // Red, green, blue
	localparam int PIX_W   = 8;
	localparam int GAIN_W  = 12;  // 4.8 fixed point
	localparam int FRAC    = 8;
	localparam int PWR_W   = 10;
	localparam int SUM_W   = 12;
	localparam int CNT_W   = 22;  // Enough for a full 1080p frame
	localparam int BIN_N   = 16;
	localparam int BIN_W   = 4;
	localparam int WGT_W   = 5;
	localparam int WGT_SH  = 4;   // Weight of 16 means all digital
	localparam int DIV_NW  = 32;
	localparam int DIV_DW  = 16;
	localparam int DIV_CW  = 6;
	localparam int BUF_W   = 2 + NCH * PIX_W;
	localparam int BUF_AW  = 1;   // Two entries
	localparam int BUF_CW  = 2;

	localparam logic [GAIN_W-1:0] GAIN_ONE  = 12'h100;
	localparam logic [GAIN_W-1:0] GAIN_MAX  = 12'hFFF;
	localparam logic [PIX_W-1:0]  PIX_FULL  = 8'hFF;
	localparam logic [BIN_W-1:0]  BIN_TOP   = 4'hF;
	localparam logic [BIN_W-1:0]  BIN_BOT   = 4'h0;
	localparam logic [BIN_W-1:0]  BIN_FILL  = 4'hF;
	localparam logic [WGT_W-1:0]  WGT_FULL  = 5'h10;
	localparam logic [PWR_W-1:0]  PWR_MAX   = 10'h3FF;
	localparam logic [1:0]        CH_FIRST  = 2'h0;
	localparam logic [1:0]        CH_LAST   = 2'h2;
	localparam logic [DIV_CW-1:0] DIV_STEPS = 6'h20;
	localparam logic [BUF_CW-1:0] BUF_FULL  = 2'h2;

	typedef enum logic {AIG_PWR_SAVE, AIG_BRIGHT} aig_mode_e;
	typedef enum logic [2:0] {
		ST_IDLE, ST_SCAN, ST_HDIV, ST_PDIV, ST_EDIV, ST_DONE
	} aig_state_e;
endpackage

// *** logic/aig_div.sv ***
// Purpose: Serial restoring divider shared by all gain and power steps
// Assumes: start only while not busy
// Notes:   A zero divisor yields all ones, which callers clamp
`timescale 1ns/1ps
module aig_div (
	input  wire logic                       clk,
	input  wire logic                       rst,
	input  wire logic                       start,
	input  wire logic [aig_pkg::DIV_NW-1:0] num,
	input  wire logic [aig_pkg::DIV_DW-1:0] den,
	output logic                            busy,
	output logic                            done,
	output logic [aig_pkg::DIV_NW-1:0]      quo
);
	logic [aig_pkg::DIV_DW-1:0] rem_r;
	logic [aig_pkg::DIV_NW-1:0] quo_r;
	logic [aig_pkg::DIV_CW-1:0] cnt_r;
	logic                       done_r;
	logic [aig_pkg::DIV_DW:0]   trial;
	logic                       fits;

	// One quotient bit per cycle
	assign trial = {rem_r, quo_r[aig_pkg::DIV_NW-1]};
	assign fits  = trial >= {1'b0, den};
	assign busy  = cnt_r != '0;
	assign done  = done_r;
	assign quo   = quo_r;

	// Shift, trial subtract, count down
	always_ff @(posedge clk) begin
		done_r <= 1'b0;
		if (rst) begin
			rem_r <= '0;
			quo_r <= '0;
			cnt_r <= '0;
		end else if (start && !busy) begin
			rem_r <= '0;
			quo_r <= num;
			cnt_r <= aig_pkg::DIV_STEPS;
		end else if (busy) begin
			rem_r <= fits ? trial[aig_pkg::DIV_DW-1:0] - den
			              : trial[aig_pkg::DIV_DW-1:0];
			quo_r <= {quo_r[aig_pkg::DIV_NW-2:0], fits};
			cnt_r <= cnt_r - 1'b1;
			done_r <= cnt_r == 6'h01;
		end
	end
endmodule

// *** logic/aig_buf.sv ***
// Purpose: Two-entry buffer in the pixel path
// Assumes: Single clock, synchronous reset
// Notes:   in_ready falls only when both entries hold words
`timescale 1ns/1ps
module aig_buf #(
	parameter int W = aig_pkg::BUF_W
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	logic [W-1:0]               mem_r [2];
	logic [aig_pkg::BUF_AW-1:0] wp_r;
	logic [aig_pkg::BUF_AW-1:0] rp_r;
	logic [aig_pkg::BUF_CW-1:0] cnt_r;
	logic                       wr;
	logic                       rd;

	// Honest full and empty from the fill count
	assign in_ready  = cnt_r != aig_pkg::BUF_FULL;
	assign out_valid = cnt_r != '0;
	assign out_data  = mem_r[rp_r];
	assign wr        = in_valid && in_ready;
	assign rd        = out_valid && out_ready;

	// Pointers and storage
	always_ff @(posedge clk) begin
		if (rst) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
			mem_r[0] <= '0;
			mem_r[1] <= '0;
		end else begin
			if (wr) begin
				mem_r[wp_r] <= in_data;
				wp_r <= wp_r + 1'b1;
			end
			if (rd)
				rp_r <= rp_r + 1'b1;
			if (wr && !rd)
				cnt_r <= cnt_r + 1'b1;
			else if (rd && !wr)
				cnt_r <= cnt_r - 1'b1;
		end
	end
endmodule

// *** logic/aig_top.sv ***
// Purpose: Per-frame adaptive gain and LED power for the pixel stream
// Assumes: Frames framed by IN_SOF/IN_EOF, one pixel per accepted beat
// Notes:   Results computed after a frame are used from the next SOF
`timescale 1ns/1ps
// How it works
// - Each frame is histogrammed per channel to derive one gain each.
// - Every pixel of a channel is multiplied by that channel's one gain.
// - The gain lifts the level where only CLIP_LIMIT pixels lie above.
// - Each of the red, green and blue LEDs gets its own power output.
// - Gain and LED power per channel come from one joint computation.
// - The host weight splits each correction between gain and power.
// - Gain times relative power is equal for all channels: white holds.
// - When enabled, MODE picks power reduction or enhanced brightness.
// - Power reduction keeps brightness and cuts power by the gain.
// - Enhanced brightness rescales powers to the static power total.
module aig_top (
	input  wire logic                        SYS_CLK,
	input  wire logic                        RST,
	input  wire logic                        ENABLE,
	input  wire logic                        MODE,
	input  wire logic [aig_pkg::WGT_W-1:0]   DIGITAL_WEIGHT,
	input  wire logic [aig_pkg::CNT_W-1:0]   CLIP_LIMIT,
	input  wire logic [aig_pkg::PWR_W-1:0]   STATIC_PWR_R,
	input  wire logic [aig_pkg::PWR_W-1:0]   STATIC_PWR_G,
	input  wire logic [aig_pkg::PWR_W-1:0]   STATIC_PWR_B,
	input  wire logic                        IN_VALID,
	output logic                             IN_READY,
	input  wire logic                        IN_SOF,
	input  wire logic                        IN_EOF,
	input  wire logic [aig_pkg::PIX_W-1:0]   IN_R,
	input  wire logic [aig_pkg::PIX_W-1:0]   IN_G,
	input  wire logic [aig_pkg::PIX_W-1:0]   IN_B,
	output logic                             OUT_VALID,
	input  wire logic                        OUT_READY,
	output logic                             OUT_SOF,
	output logic                             OUT_EOF,
	output logic [aig_pkg::PIX_W-1:0]        OUT_R,
	output logic [aig_pkg::PIX_W-1:0]        OUT_G,
	output logic [aig_pkg::PIX_W-1:0]        OUT_B,
	output logic [aig_pkg::PWR_W-1:0]        LED_PWR_R,
	output logic [aig_pkg::PWR_W-1:0]        LED_PWR_G,
	output logic [aig_pkg::PWR_W-1:0]        LED_PWR_B,
	output logic [aig_pkg::GAIN_W-1:0]       GAIN_R,
	output logic [aig_pkg::GAIN_W-1:0]       GAIN_G,
	output logic [aig_pkg::GAIN_W-1:0]       GAIN_B,
	output logic                             BUSY
);
	localparam int NCH = aig_pkg::NCH;
	localparam int PW  = aig_pkg::PIX_W;
	localparam int GW  = aig_pkg::GAIN_W;
	localparam int QW  = aig_pkg::PWR_W;

	aig_pkg::aig_state_e state_r;
	aig_pkg::aig_mode_e  mode_r;

	logic [PW-1:0]                   pix_in   [NCH];
	logic [QW-1:0]                   stat_in  [NCH];
	logic [PW-1:0]                   pix_sat  [NCH];
	logic [GW-1:0]                   gain_use [NCH];
	logic [aig_pkg::CNT_W-1:0]       hist_r   [NCH][aig_pkg::BIN_N];
	logic [aig_pkg::CNT_W:0]         acc_r    [NCH];
	logic [aig_pkg::BIN_W-1:0]       knee_r   [NCH];
	logic                            found_r  [NCH];
	logic [GW-1:0]                   wg_r     [NCH];
	logic [QW-1:0]                   pw_r     [NCH];
	logic [QW-1:0]                   stat_r   [NCH];
	logic [GW-1:0]                   act_gain_r [NCH];
	logic [QW-1:0]                   act_pwr_r  [NCH];
	logic [GW-1:0]                   pend_gain_r [NCH];
	logic [QW-1:0]                   pend_pwr_r  [NCH];
	logic [GW-1:0]                   gain_out_r [NCH];
	logic [QW-1:0]                   led_out_r  [NCH];
	logic                            pend_v_r;
	logic                            act_v_r;
	logic [aig_pkg::BIN_W-1:0]       idx_r;
	logic [1:0]                      ch_r;
	logic                            wait_r;
	logic [aig_pkg::WGT_W-1:0]       wgt_r;
	logic [aig_pkg::SUM_W-1:0]       sum_r;
	logic [aig_pkg::SUM_W-1:0]       psum_r;

	logic                            in_ready_w;
	logic                            buf_ready;
	logic                            in_fire;
	logic                            sof_swap;
	logic [aig_pkg::BUF_W-1:0]       buf_in;
	logic [aig_pkg::BUF_W-1:0]       buf_out;
	logic                            div_start;
	logic                            div_busy;
	logic                            div_done;
	logic [aig_pkg::DIV_NW-1:0]      div_num;
	logic [aig_pkg::DIV_DW-1:0]      div_den;
	logic [aig_pkg::DIV_NW-1:0]      div_quo;
	logic [PW-1:0]                   knee_val;
	logic [GW-1:0]                   h_clip;
	logic [GW-1:0]                   h_ext;
	logic [GW+aig_pkg::WGT_W-1:0]    h_mul;
	logic [GW-1:0]                   g_new;
	logic [QW-1:0]                   p_clip;
	logic [QW+aig_pkg::SUM_W-1:0]    e_mul;
	logic                            last_ch;

	// Channel views of the flat ports
	assign pix_in[0]  = IN_R;
	assign pix_in[1]  = IN_G;
	assign pix_in[2]  = IN_B;
	assign stat_in[0] = STATIC_PWR_R;
	assign stat_in[1] = STATIC_PWR_G;
	assign stat_in[2] = STATIC_PWR_B;

	// Input stalls during the bin scan so the histogram stays frozen
	assign in_ready_w = buf_ready && state_r != aig_pkg::ST_SCAN;
	assign IN_READY   = in_ready_w;
	assign in_fire    = IN_VALID && in_ready_w;
	assign sof_swap   = in_fire && IN_SOF && pend_v_r;
	assign BUSY       = state_r != aig_pkg::ST_IDLE;

	genvar c, b;
	generate
		for (c = 0; c < NCH; c++) begin : g_ch
			logic [PW+GW-1:0]          prod;
			logic [aig_pkg::CNT_W:0]   acc_nxt;
			// New set takes effect on the SOF pixel itself
			assign gain_use[c] = !ENABLE ? aig_pkg::GAIN_ONE :
				sof_swap ? pend_gain_r[c] : act_gain_r[c];
			assign prod = pix_in[c] * gain_use[c];
			// Clip above full scale; the knee keeps clipped pixels few
			assign pix_sat[c] = |prod[PW+GW-1:PW+aig_pkg::FRAC] ?
				aig_pkg::PIX_FULL : prod[PW+aig_pkg::FRAC-1:aig_pkg::FRAC];
			assign acc_nxt = acc_r[c] + {1'b0, hist_r[c][idx_r]};

			// Coarse histogram on the top bits, restarted by SOF
			for (b = 0; b < aig_pkg::BIN_N; b++) begin : g_bin
				logic hit;
				assign hit = pix_in[c][PW-1:PW-aig_pkg::BIN_W] == b;
				always_ff @(posedge SYS_CLK) begin
					if (RST)
						hist_r[c][b] <= '0;
					else if (in_fire && IN_SOF)
						hist_r[c][b] <= {{(aig_pkg::CNT_W-1){1'b0}}, hit};
					else if (in_fire && hit)
						hist_r[c][b] <= hist_r[c][b] + 1'b1;
				end
			end

			// Walk down from the top bin until the limit is passed
			always_ff @(posedge SYS_CLK) begin
				if (RST || state_r == aig_pkg::ST_IDLE) begin
					acc_r[c]   <= '0;
					found_r[c] <= 1'b0;
					knee_r[c]  <= aig_pkg::BIN_BOT;
				end else if (state_r == aig_pkg::ST_SCAN && !found_r[c]) begin
					acc_r[c]   <= acc_nxt;
					knee_r[c]  <= idx_r;
					found_r[c] <= acc_nxt > {1'b0, CLIP_LIMIT};
				end
			end

			// Outputs registered; static set when disabled or before any frame
			always_ff @(posedge SYS_CLK) begin
				if (RST) begin
					gain_out_r[c] <= aig_pkg::GAIN_ONE;
					led_out_r[c]  <= '0;
				end else begin
					gain_out_r[c] <= gain_use[c];
					led_out_r[c]  <= (ENABLE && act_v_r) ? act_pwr_r[c]
					                                     : stat_in[c];
				end
			end
		end
	endgenerate

	assign GAIN_R    = gain_out_r[0];
	assign GAIN_G    = gain_out_r[1];
	assign GAIN_B    = gain_out_r[2];
	assign LED_PWR_R = led_out_r[0];
	assign LED_PWR_G = led_out_r[1];
	assign LED_PWR_B = led_out_r[2];

	// Result shaping for the channel being worked on
	assign last_ch  = ch_r == aig_pkg::CH_LAST;
	assign knee_val = {knee_r[ch_r], aig_pkg::BIN_FILL};
	assign h_clip   = |div_quo[aig_pkg::DIV_NW-1:GW] ? aig_pkg::GAIN_MAX
	                                                 : div_quo[GW-1:0];
	assign h_ext    = h_clip - aig_pkg::GAIN_ONE;
	assign h_mul    = h_ext * wgt_r;
	assign g_new    = aig_pkg::GAIN_ONE +
		h_mul[GW+aig_pkg::WGT_SH-1:aig_pkg::WGT_SH];
	assign p_clip   = |div_quo[aig_pkg::DIV_NW-1:QW] ? aig_pkg::PWR_MAX
	                                                 : div_quo[QW-1:0];
	assign e_mul    = pw_r[ch_r] * sum_r;

	// Divider operands per step: headroom, power share, power rescale
	assign div_start = !wait_r && (state_r == aig_pkg::ST_HDIV ||
		state_r == aig_pkg::ST_PDIV || state_r == aig_pkg::ST_EDIV);
	assign div_num = state_r == aig_pkg::ST_HDIV ?
		{{(aig_pkg::DIV_NW-PW-aig_pkg::FRAC){1'b0}}, aig_pkg::PIX_FULL,
		 {aig_pkg::FRAC{1'b0}}} :
		state_r == aig_pkg::ST_PDIV ?
		{{(aig_pkg::DIV_NW-QW-aig_pkg::FRAC){1'b0}}, stat_r[ch_r],
		 {aig_pkg::FRAC{1'b0}}} :
		{{(aig_pkg::DIV_NW-QW-aig_pkg::SUM_W){1'b0}}, e_mul};
	assign div_den = state_r == aig_pkg::ST_HDIV ?
		{{(aig_pkg::DIV_DW-PW){1'b0}}, knee_val} :
		state_r == aig_pkg::ST_PDIV ?
		{{(aig_pkg::DIV_DW-GW){1'b0}}, wg_r[ch_r]} :
		{{(aig_pkg::DIV_DW-aig_pkg::SUM_W){1'b0}}, psum_r};

	aig_div u_div (
		.clk   (SYS_CLK),
		.rst   (RST),
		.start (div_start),
		.num   (div_num),
		.den   (div_den),
		.busy  (div_busy),
		.done  (div_done),
		.quo   (div_quo)
	);

	// Frame sequencer: scan, gains, powers, optional rescale, publish
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			state_r <= aig_pkg::ST_IDLE;
			mode_r  <= aig_pkg::AIG_PWR_SAVE;
			idx_r   <= aig_pkg::BIN_TOP;
			ch_r    <= aig_pkg::CH_FIRST;
			wait_r  <= 1'b0;
			wgt_r   <= '0;
			sum_r   <= '0;
			psum_r  <= '0;
		end else begin
			if (div_start)
				wait_r <= 1'b1;
			else if (div_done)
				wait_r <= 1'b0;
			unique case (state_r)
				aig_pkg::ST_IDLE: begin
					// Mode, weight and static powers are locked at EOF; CLIP_LIMIT is read live during the scan
					if (in_fire && IN_EOF && ENABLE) begin
						state_r <= aig_pkg::ST_SCAN;
						idx_r   <= aig_pkg::BIN_TOP;
						mode_r  <= aig_pkg::aig_mode_e'(MODE);
						wgt_r   <= DIGITAL_WEIGHT > aig_pkg::WGT_FULL ?
						           aig_pkg::WGT_FULL : DIGITAL_WEIGHT;
						sum_r   <= {2'b00, STATIC_PWR_R} +
						           {2'b00, STATIC_PWR_G} +
						           {2'b00, STATIC_PWR_B};
					end
				end
				aig_pkg::ST_SCAN: begin
					idx_r <= idx_r - 1'b1;
					if (idx_r == aig_pkg::BIN_BOT) begin
						state_r <= aig_pkg::ST_HDIV;
						ch_r    <= aig_pkg::CH_FIRST;
						psum_r  <= '0;
					end
				end
				aig_pkg::ST_HDIV: begin
					if (div_done) begin
						ch_r <= last_ch ? aig_pkg::CH_FIRST : ch_r + 1'b1;
						if (last_ch)
							state_r <= aig_pkg::ST_PDIV;
					end
				end
				aig_pkg::ST_PDIV: begin
					if (div_done) begin
						psum_r <= psum_r + {2'b00, p_clip};
						ch_r <= last_ch ? aig_pkg::CH_FIRST : ch_r + 1'b1;
						if (last_ch)
							state_r <= mode_r == aig_pkg::AIG_BRIGHT ?
							           aig_pkg::ST_EDIV : aig_pkg::ST_DONE;
					end
				end
				aig_pkg::ST_EDIV: begin
					if (div_done) begin
						ch_r <= last_ch ? aig_pkg::CH_FIRST : ch_r + 1'b1;
						if (last_ch)
							state_r <= aig_pkg::ST_DONE;
					end
				end
				aig_pkg::ST_DONE:
					state_r <= aig_pkg::ST_IDLE;
			endcase
		end
	end

	// Per-channel results of each divider step
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			for (int i = 0; i < NCH; i++) begin
				wg_r[i]   <= aig_pkg::GAIN_ONE;
				pw_r[i]   <= '0;
				stat_r[i] <= '0;
			end
		end else begin
			if (state_r == aig_pkg::ST_IDLE && in_fire && IN_EOF)
				for (int i = 0; i < NCH; i++)
					stat_r[i] <= stat_in[i];
			if (div_done && state_r == aig_pkg::ST_HDIV)
				wg_r[ch_r] <= g_new;
			if (div_done && state_r == aig_pkg::ST_PDIV)
				pw_r[ch_r] <= p_clip;
			if (div_done && state_r == aig_pkg::ST_EDIV)
				pw_r[ch_r] <= psum_r == '0 ? '0 : p_clip;
		end
	end

	// Publish on DONE, apply at SOF; a publish in that cycle wins
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			pend_v_r <= 1'b0;
			act_v_r  <= 1'b0;
			for (int i = 0; i < NCH; i++) begin
				act_gain_r[i]  <= aig_pkg::GAIN_ONE;
				act_pwr_r[i]   <= '0;
				pend_gain_r[i] <= aig_pkg::GAIN_ONE;
				pend_pwr_r[i]  <= '0;
			end
		end else begin
			if (sof_swap) begin
				pend_v_r <= 1'b0;
				act_v_r  <= 1'b1;
				for (int i = 0; i < NCH; i++) begin
					act_gain_r[i] <= pend_gain_r[i];
					act_pwr_r[i]  <= pend_pwr_r[i];
				end
			end
			if (state_r == aig_pkg::ST_DONE) begin
				pend_v_r <= 1'b1;
				for (int i = 0; i < NCH; i++) begin
					pend_gain_r[i] <= wg_r[i];
					pend_pwr_r[i]  <= pw_r[i];
				end
			end
		end
	end

	// Output buffer absorbs receiver stalls without dropping pixels
	assign buf_in = {IN_SOF, IN_EOF, pix_sat[0], pix_sat[1], pix_sat[2]};

	aig_buf #(
		.W (aig_pkg::BUF_W)
	) u_buf (
		.clk       (SYS_CLK),
		.rst       (RST),
		.in_valid  (IN_VALID && state_r != aig_pkg::ST_SCAN),
		.in_ready  (buf_ready),
		.in_data   (buf_in),
		.out_valid (OUT_VALID),
		.out_ready (OUT_READY),
		.out_data  (buf_out)
	);

	assign OUT_SOF = buf_out[aig_pkg::BUF_W-1];
	assign OUT_EOF = buf_out[aig_pkg::BUF_W-2];
	assign OUT_R   = buf_out[3*PW-1:2*PW];
	assign OUT_G   = buf_out[2*PW-1:PW];
	assign OUT_B   = buf_out[PW-1:0];
endmodule

// *** verification/aig_top_sva.sv ***
// Purpose: Port checker for the adaptive illumination gain top
// Assumes: Static LED powers held steady while enabled
// Notes:   Hold checks skip two edges after reset and enable changes
`timescale 1ns/1ps
module aig_top_sva (
	input wire logic                        SYS_CLK,
	input wire logic                        RST,
	input wire logic                        ENABLE,
	input wire logic                        IN_VALID,
	input wire logic                        IN_READY,
	input wire logic                        IN_SOF,
	input wire logic                        IN_EOF,
	input wire logic                        OUT_VALID,
	input wire logic                        OUT_READY,
	input wire logic [aig_pkg::PIX_W-1:0]   OUT_R,
	input wire logic [aig_pkg::PIX_W-1:0]   OUT_G,
	input wire logic [aig_pkg::PIX_W-1:0]   OUT_B,
	input wire logic [aig_pkg::PWR_W-1:0]   STATIC_PWR_R,
	input wire logic [aig_pkg::PWR_W-1:0]   STATIC_PWR_G,
	input wire logic [aig_pkg::PWR_W-1:0]   STATIC_PWR_B,
	input wire logic [aig_pkg::PWR_W-1:0]   LED_PWR_R,
	input wire logic [aig_pkg::PWR_W-1:0]   LED_PWR_G,
	input wire logic [aig_pkg::PWR_W-1:0]   LED_PWR_B,
	input wire logic [aig_pkg::GAIN_W-1:0]  GAIN_R,
	input wire logic [aig_pkg::GAIN_W-1:0]  GAIN_G,
	input wire logic [aig_pkg::GAIN_W-1:0]  GAIN_B,
	input wire logic                        BUSY
);
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (RST);

	// Outputs registered one cycle late, so two edges of history needed
	a_off_unity: assert property (!ENABLE && $past(!ENABLE) |->
		GAIN_R == aig_pkg::GAIN_ONE && GAIN_G == aig_pkg::GAIN_ONE
		&& GAIN_B == aig_pkg::GAIN_ONE) else $error("gain not unity");
	a_off_static: assert property (!ENABLE && $past(!ENABLE)
		&& !$past(RST) |-> LED_PWR_R == STATIC_PWR_R
		&& LED_PWR_G == STATIC_PWR_G && LED_PWR_B == STATIC_PWR_B)
		else $error("led power not static");
	a_gain_hold: assert property (ENABLE && $past(ENABLE)
		&& $past(ENABLE, 2) && !$past(RST) && !$past(RST, 2)
		&& !$past(IN_VALID && IN_READY && IN_SOF) |-> $stable(GAIN_R)
		&& $stable(GAIN_G) && $stable(GAIN_B)) else $error("gain moved");
	a_led_hold: assert property (ENABLE && $past(ENABLE)
		&& $past(ENABLE, 2) && !$past(RST) && !$past(RST, 2)
		&& !$past(IN_VALID && IN_READY && IN_SOF, 2) |-> $stable(LED_PWR_R)
		&& $stable(LED_PWR_G) && $stable(LED_PWR_B))
		else $error("led power moved");
	a_eof_busy: assert property (IN_VALID && IN_READY && IN_EOF
		&& ENABLE && !BUSY |=> BUSY) else $error("no analysis on eof");
	// Scan refuses input for sixteen cycles
	a_scan_refuse: assert property ($rose(BUSY) |->
		!IN_READY [*8] ##1 !IN_READY [*8]) else $error("taken in scan");
	a_busy_bound: assert property ($rose(BUSY) |->
		##[16:1000] !BUSY) else $error("computation hangs");
	a_out_stand: assert property (OUT_VALID && !OUT_READY |=>
		OUT_VALID && $stable(OUT_R) && $stable(OUT_G) && $stable(OUT_B))
		else $error("output word lost");
	a_room_ready: assert property (!BUSY && !OUT_VALID |->
		IN_READY) else $error("empty buffer refuses");
endmodule

// *** verification/aig_sink.sv ***
// Purpose: Downstream pixel path model with random back-pressure
// Assumes: Words move on valid and ready high at a rising edge
// Notes:   Counts words so the bench can prove none were dropped
`timescale 1ns/1ps
module aig_sink (
	input  wire logic   clk,
	input  wire logic   rst,
	input  wire logic   stall_en,
	input  wire logic   valid,
	output logic        ready,
	output logic [15:0] taken
);
	// Random ready fills the two-entry buffer
	always @(posedge clk) begin
		if (rst) begin
			ready <= 1'b0;
			taken <= 16'h0000;
		end else begin
			ready <= stall_en ? 1'($urandom_range(1, 0)) : 1'b1;
			taken <= taken + 16'(valid && ready);
		end
	end
endmodule

// *** verification/adaptive_illumination_gain_tb.sv ***
// Purpose: Frame-level bench for the adaptive illumination gain
// Assumes: Eight-beat frames, static powers constant through the run
// Notes:   Driver queues expected pixels, watcher checks them
`timescale 1ns/1ps
module adaptive_illumination_gain_tb;
	logic                       SYS_CLK, RST, ENABLE, MODE, IN_VALID;
	logic                       IN_SOF, IN_EOF, OUT_READY, OUT_VALID;
	logic                       OUT_SOF, OUT_EOF, IN_READY, BUSY;
	logic [aig_pkg::WGT_W-1:0]  DIGITAL_WEIGHT;
	logic [aig_pkg::CNT_W-1:0]  CLIP_LIMIT;
	logic [aig_pkg::PIX_W-1:0]  IN_R, IN_G, IN_B, OUT_R, OUT_G, OUT_B;
	logic [aig_pkg::PWR_W-1:0]  STATIC_PWR_R, STATIC_PWR_G, STATIC_PWR_B;
	logic [aig_pkg::PWR_W-1:0]  LED_PWR_R, LED_PWR_G, LED_PWR_B;
	logic [aig_pkg::GAIN_W-1:0] GAIN_R, GAIN_G, GAIN_B;
	logic [15:0]                sink_cnt;
	logic [aig_pkg::BUF_W-1:0]  exp_q[$];
	logic [aig_pkg::GAIN_W-1:0] cur_g[3], nxt_g[3];
	logic [aig_pkg::PWR_W-1:0]  cur_p[3], nxt_p[3], st_p[3];
	logic [7:0]                 px[3][8];
	int                         errors, n_tests, sent;
	// Frames: enable, mode, weight, clip, forced full-scale reds, masks
	int                         f_en[7] = '{0, 1, 1, 1, 1, 1, 0};
	int                         f_md[7] = '{0, 0, 1, 0, 1, 0, 0};
	int                         f_w[7] = '{16, 16, 8, 20, 0, 16, 16};
	int                         f_cl[7] = '{0, 0, 4, 2, 0, 0, 0};
	int                         f_hi[7] = '{0, 0, 4, 0, 0, 0, 0};
	logic [23:0]                f_mk[7] = '{24'hFFFFFF, 24'h3F7F1F,
		24'h3FFF1F, 24'h7F3F0F, 24'hFFFFFF, 24'h1F3F7F, 24'hFFFFFF};

	aig_top i_dut (.SYS_CLK(SYS_CLK), .RST(RST), .ENABLE(ENABLE),
		.MODE(MODE), .DIGITAL_WEIGHT(DIGITAL_WEIGHT),
		.CLIP_LIMIT(CLIP_LIMIT), .STATIC_PWR_R(STATIC_PWR_R),
		.STATIC_PWR_G(STATIC_PWR_G), .STATIC_PWR_B(STATIC_PWR_B),
		.IN_VALID(IN_VALID), .IN_READY(IN_READY), .IN_SOF(IN_SOF),
		.IN_EOF(IN_EOF), .IN_R(IN_R), .IN_G(IN_G), .IN_B(IN_B),
		.OUT_VALID(OUT_VALID), .OUT_READY(OUT_READY), .OUT_SOF(OUT_SOF),
		.OUT_EOF(OUT_EOF), .OUT_R(OUT_R), .OUT_G(OUT_G), .OUT_B(OUT_B),
		.LED_PWR_R(LED_PWR_R), .LED_PWR_G(LED_PWR_G),
		.LED_PWR_B(LED_PWR_B), .GAIN_R(GAIN_R), .GAIN_G(GAIN_G),
		.GAIN_B(GAIN_B), .BUSY(BUSY));
	aig_sink i_sink (.clk(SYS_CLK), .rst(RST), .stall_en(1'b1),
		.valid(OUT_VALID), .ready(OUT_READY), .taken(sink_cnt));

	initial begin
		SYS_CLK = 1'b0;
		forever #5 SYS_CLK = ~SYS_CLK;
	end

	// Saturating multiply by a 4.8 gain
	function automatic logic [7:0] sat(input logic [7:0] d,
		input logic [11:0] g);
		logic [19:0] v;
		v = (d * g) >> 8;
		return (v > 20'h0000FF) ? 8'hFF : v[7:0];
	endfunction

	// Knee from the top bin down, then headroom split by the weight
	function automatic logic [11:0] calc_gain(input int c, cl, w);
		int cnt, h, fnd;
		logic [7:0] knee;
		cnt = 0;
		fnd = 0;
		knee = 8'hFF;
		for (int b = 15; b >= 0; b--) begin
			for (int i = 0; i < 8; i++) begin
				cnt += int'(px[c][i][7:4] == b);
			end
			if (fnd == 0 && cnt > cl) begin
				knee = {4'(b), 4'hF};
				fnd = 1;
			end
		end
		h = 'hFF00 / int'(knee);
		h = (h > 'hFFF) ? 'hFFF : h;
		w = (w > 16) ? 16 : w;
		return 12'('h100 + (((h - 'h100) * w) >> 4));
	endfunction

	task automatic chk(input string nm, input logic [25:0] e, s);
		n_tests++;
		if (s !== e) begin
			errors++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic end_of_test;
		$display("Comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic give_up(input string nm);
		errors++;
		$display("Error %s expected done seen timeout", nm);
		end_of_test();
	endtask

	// Request held from a rising edge until ready is seen at an edge
	task automatic send_beat(input logic s, e, input logic [7:0] r, g, b);
		int k;
		IN_VALID <= 1'b1;
		IN_SOF <= s;
		IN_EOF <= e;
		IN_R <= r;
		IN_G <= g;
		IN_B <= b;
		for (k = 0; k < 1000; k++) begin
			@(negedge SYS_CLK);
			if (IN_READY === 1'b1) break;
		end
		if (k == 1000) give_up("in_ready");
		@(posedge SYS_CLK);
		exp_q.push_back({s, e, sat(r, cur_g[0]), sat(g, cur_g[1]),
			sat(b, cur_g[2])});
		sent++;
	endtask

	task automatic run_frame(input int f);
		int k, s, t, v;
		ENABLE <= 1'(f_en[f]);
		MODE <= 1'(f_md[f]);
		DIGITAL_WEIGHT <= 5'(f_w[f]);
		CLIP_LIMIT <= 22'(f_cl[f]);
		for (int c = 0; c < 3; c++) begin
			for (int i = 0; i < 8; i++) begin
				px[c][i] = (c == 0 && i < f_hi[f]) ? 8'hFF :
					8'($urandom) & f_mk[f][23-8*c -: 8];
			end
			if (f_en[f] == 0) begin
				cur_g[c] = aig_pkg::GAIN_ONE;
				cur_p[c] = st_p[c];
			end
		end
		for (int i = 0; i < 8; i++) begin
			if ($urandom_range(3, 0) == 0) begin
				IN_VALID <= 1'b0;
				@(posedge SYS_CLK);
			end
			send_beat(i == 0, i == 7, px[0][i], px[1][i], px[2][i]);
		end
		IN_VALID <= 1'b0;
		repeat (2) @(posedge SYS_CLK);
		@(negedge SYS_CLK);
		chk("gain_r", 26'(cur_g[0]), 26'(GAIN_R));
		chk("gain_g", 26'(cur_g[1]), 26'(GAIN_G));
		chk("gain_b", 26'(cur_g[2]), 26'(GAIN_B));
		chk("led_r", 26'(cur_p[0]), 26'(LED_PWR_R));
		chk("led_g", 26'(cur_p[1]), 26'(LED_PWR_G));
		chk("led_b", 26'(cur_p[2]), 26'(LED_PWR_B));
		// Next set worked out here, then waited for before the next frame
		if (f_en[f] != 0) begin
			s = 0;
			t = 0;
			for (int c = 0; c < 3; c++) begin
				nxt_g[c] = calc_gain(c, f_cl[f], f_w[f]);
				v = (int'(st_p[c]) << 8) / int'(nxt_g[c]);
				nxt_p[c] = 10'((v > 'h3FF) ? 'h3FF : v);
				s += int'(nxt_p[c]);
				t += int'(st_p[c]);
			end
			for (int c = 0; c < 3; c++) begin
				v = (s == 0) ? 0 : int'(nxt_p[c]) * t / s;
				nxt_p[c] = (f_md[f] == 0) ? nxt_p[c] :
					10'((v > 'h3FF) ? 'h3FF : v);
			end
			for (k = 0; k < 1000; k++) begin
				@(negedge SYS_CLK);
				if (BUSY === 1'b0) break;
			end
			if (k == 1000) give_up("busy");
			cur_g = nxt_g;
			cur_p = nxt_p;
		end
		@(posedge SYS_CLK);
	endtask

	// Output watcher: each word leaving is matched to the oldest note
	always @(negedge SYS_CLK) begin
		if (OUT_VALID === 1'b1 && OUT_READY === 1'b1) begin
			if (exp_q.size() == 0) begin
				errors++;
				$display("Error pixel expected none seen %h", OUT_R);
			end else begin
				chk("pixel", exp_q.pop_front(), {OUT_SOF, OUT_EOF, OUT_R,
					OUT_G, OUT_B});
			end
		end
	end

	initial begin
		int k;
		void'($urandom(37));
		{RST, ENABLE, MODE, IN_VALID, IN_SOF, IN_EOF} = 6'b100000;
		{IN_R, IN_G, IN_B, DIGITAL_WEIGHT, CLIP_LIMIT} = '0;
		st_p = '{10'h200, 10'h300, 10'h180};
		{STATIC_PWR_R, STATIC_PWR_G, STATIC_PWR_B} = {st_p[0], st_p[1],
			st_p[2]};
		cur_g = '{3{aig_pkg::GAIN_ONE}};
		cur_p = st_p;
		repeat (20) @(posedge SYS_CLK);
		RST <= 1'b0;
		@(negedge SYS_CLK);
		chk("out_valid", 26'h0000000, 26'(OUT_VALID));
		chk("gain_rst", 26'(aig_pkg::GAIN_ONE), 26'(GAIN_R));
		@(posedge SYS_CLK);
		for (int f = 0; f < 7; f++) begin
			run_frame(f);
		end
		for (k = 0; k < 2000; k++) begin
			@(negedge SYS_CLK);
			if (exp_q.size() == 0) break;
		end
		if (k == 2000) give_up("drain");
		@(negedge SYS_CLK);
		chk("sink_count", 26'(sent), 26'(sink_cnt));
		end_of_test();
	end
endmodule

bind aig_top aig_top_sva i_sva (.SYS_CLK(SYS_CLK), .RST(RST),
	.ENABLE(ENABLE), .IN_VALID(IN_VALID), .IN_READY(IN_READY),
	.IN_SOF(IN_SOF), .IN_EOF(IN_EOF), .OUT_VALID(OUT_VALID),
	.OUT_READY(OUT_READY), .OUT_R(OUT_R), .OUT_G(OUT_G), .OUT_B(OUT_B),
	.STATIC_PWR_R(STATIC_PWR_R), .STATIC_PWR_G(STATIC_PWR_G),
	.STATIC_PWR_B(STATIC_PWR_B), .LED_PWR_R(LED_PWR_R),
	.LED_PWR_G(LED_PWR_G), .LED_PWR_B(LED_PWR_B), .GAIN_R(GAIN_R),
	.GAIN_G(GAIN_G), .GAIN_B(GAIN_B), .BUSY(BUSY));
